// ---- condition_flag_evaluator.sv ----
// Condition flag evaluator with datapath conventions, APB register access
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Operation
// - Code 0001 true when carry set (unsigned lower).
// - Code 1001 true when carry clear (unsigned greater or equal).
// - Code 0011 true when carry or zero set; 1011 when both clear.
// - Code 0101 is always true whatever the flags hold.
// - Code 0110 true when sign xor overflow; 1110 when not.
// - Code 0111 true on (sign xor overflow) or zero; 1111 otherwise.
// - Saturating results clamp to 7FFFFFFF and 80000000 as two's complement.
// - Sign extension copies the top bit; zero extension fills zeros.
// - Result-marked flags follow result, unmarked keep, zero-marked cleared.
// - Restore-marked flags reload from the saved flag copy.
// - Third register takes division remainder and upper product half.
// - Trap vector is a five-bit field, 00 to 1F.
// - Bit operations pick a bit in a byte with three bits.
// - Loads read byte, halfword or word of the requested size.
// - Cycle counts given as issue, repeat and latency.
module condition_flag_evaluator
  import flag_pkg::*;
#(
  parameter int DW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cond_true,
  output logic busy
);
  import flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic eval_cond(input logic [3:0] cc, input logic [FLAG_W-1:0] f);
    logic base;
    base = 1'b0;
    unique case (cc[2:0])
      3'h0: base = f[FLAG_OVERFLOW];
      3'h1: base = f[FLAG_CARRY];
      3'h2: base = f[FLAG_Z];
      3'h3: base = f[FLAG_CARRY] | f[FLAG_Z];
      3'h4: base = f[FLAG_S];
      3'h5: base = 1'b1;
      3'h6: base = f[FLAG_S] ^ f[FLAG_OVERFLOW];
      3'h7: base = (f[FLAG_S] ^ f[FLAG_OVERFLOW]) | f[FLAG_Z];
    endcase
    if (cc == CC_ALWAYS) begin
      eval_cond = 1'b1;
    end else if (cc == CC_SATURATED) begin
      eval_cond = f[FLAG_SATURATION];
    end else begin
      eval_cond = cc[3] ? ~base : base;
    end
  endfunction

  function automatic logic [31:0] extend(input logic [31:0] v, input logic [1:0] sz,
                                         input logic sgn);
    unique case (sz)
      SZ_BYTE: extend = {{24{sgn & v[7]}}, v[7:0]};
      SZ_HALF: extend = {{16{sgn & v[15]}}, v[15:0]};
      default: extend = v;
    endcase
  endfunction

  function automatic logic [31:0] saturate(input logic [32:0] wide);
    if (!wide[32] && wide[31]) begin
      saturate = CLAMP_MAX;
    end else if (wide[32] && !wide[31]) begin
      saturate = CLAMP_MIN;
    end else begin
      saturate = wide[31:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } exec_e;

  exec_e state_r;
  logic [31:0] opa_r;
  logic [31:0] opb_r;
  logic [31:0] cmd_r;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] saved_r;
  logic [31:0] result_r;
  logic [31:0] third_r;
  logic [5:0] wait_r;
  logic [3:0] last_op_r;
  logic [5:0] timing_r;
  logic [HIST_AW-1:0] hist_wp_r;
  logic [HIST_AW-1:0] hist_rp_r;
  logic [FLAG_W-1:0] hist_rdata;
  logic go;

  wire logic wr_acc = psel & penable & pwrite;
  wire logic rd_acc = psel & penable & ~pwrite;
  wire logic [3:0] op = cmd_r[CMD_OP_LSB +: 4];
  wire logic [3:0] cc = cmd_r[CMD_CC_LSB +: 4];
  wire logic [1:0] sz = cmd_r[CMD_SZ_LSB +: 2];
  wire logic [2:0] bitnum = cmd_r[CMD_BIT_LSB +: BITNUM_W];
  wire logic [9:0] upd = cmd_r[CMD_UPD_LSB +: 10];

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  logic [31:0] res_nxt;
  logic [31:0] third_nxt;
  logic [FLAG_W-1:0] calc_flags;
  logic [FLAG_W-1:0] flags_nxt;
  logic [32:0] wide;
  logic [63:0] prod;

  always_comb begin
    wide = 33'h000000000;
    prod = 64'h0000000000000000;
    res_nxt = 32'h00000000;
    third_nxt = third_r;
    calc_flags = flags_r;
    unique case (op)
      OP_ADD, OP_SATADD: wide = {opa_r[31], opa_r} + {opb_r[31], opb_r};
      OP_SUB, OP_SATSUB: wide = {opa_r[31], opa_r} - {opb_r[31], opb_r};
      default: wide = 33'h000000000;
    endcase
    unique case (op)
      OP_ADD, OP_SUB: begin
        res_nxt = wide[31:0];
        calc_flags[FLAG_CARRY] = (op == OP_ADD) ? ({1'b0, opa_r} + {1'b0, opb_r}) > 33'h0FFFFFFFF
                                                : (opa_r < opb_r);
        calc_flags[FLAG_OVERFLOW] = wide[32] ^ wide[31];
      end
      OP_SATADD, OP_SATSUB: begin
        res_nxt = saturate(wide);
        calc_flags[FLAG_OVERFLOW] = wide[32] ^ wide[31];
        calc_flags[FLAG_SATURATION] = flags_r[FLAG_SATURATION] | (wide[32] ^ wide[31]);
        calc_flags[FLAG_CARRY] = (op == OP_SATSUB) ? (opa_r < opb_r)
                                 : (({1'b0, opa_r} + {1'b0, opb_r}) > 33'h0FFFFFFFF);
      end
      OP_SEXT: res_nxt = extend(opa_r, sz, 1'b1);
      OP_ZEXT: res_nxt = extend(opa_r, sz, 1'b0);
      OP_LOAD: res_nxt = extend(opa_r, sz, ~cmd_r[31]);
      OP_MUL: begin
        prod = {{32{opa_r[31]}}, opa_r} * {{32{opb_r[31]}}, opb_r};
        res_nxt = prod[31:0];
        third_nxt = prod[63:32];
      end
      OP_MULU: begin
        prod = {32'h00000000, opa_r} * {32'h00000000, opb_r};
        res_nxt = prod[31:0];
        third_nxt = prod[63:32];
      end
      OP_DIV: begin
        if (opb_r != 32'h00000000) begin
          res_nxt = 32'($signed(opa_r) / $signed(opb_r));
          third_nxt = 32'($signed(opa_r) % $signed(opb_r));
        end
        calc_flags[FLAG_OVERFLOW] = (opb_r == 32'h00000000) ||
                                    (opa_r == CLAMP_MIN && opb_r == 32'hFFFFFFFF);
      end
      OP_DIVU: begin
        if (opb_r != 32'h00000000) begin
          res_nxt = opa_r / opb_r;
          third_nxt = opa_r % opb_r;
        end
        calc_flags[FLAG_OVERFLOW] = (opb_r == 32'h00000000);
      end
      OP_SETBIT: begin
        res_nxt = {24'h000000, opa_r[7:0] | (8'h01 << bitnum)};
        calc_flags[FLAG_Z] = ~opa_r[bitnum];
      end
      OP_TRAP: res_nxt = TRAP_BASE + {27'h0000000, opa_r[VEC_W-1:0]};
      default: res_nxt = opa_r;
    endcase
    if (op != OP_SETBIT) begin
      calc_flags[FLAG_Z] = (res_nxt == 32'h00000000);
    end
    calc_flags[FLAG_S] = res_nxt[31];
  end

  always_comb begin
    for (int i = 0; i < FLAG_W; i++) begin
      unique case (upd[2*i +: 2])
        UPD_KEEP: flags_nxt[i] = flags_r[i];
        UPD_CLEAR: flags_nxt[i] = 1'b0;
        UPD_RESULT: flags_nxt[i] = calc_flags[i];
        UPD_RESTORE: flags_nxt[i] = saved_r[i];
      endcase
    end
  end

  function automatic logic [5:0] op_cycles(input logic [3:0] o, input logic same,
                                           input logic dep);
    unique case (o)
      OP_DIV: op_cycles = DIV_CYC;
      OP_DIVU: op_cycles = DIVU_CYC;
      OP_MUL, OP_MULU: op_cycles = dep ? MUL_LATENCY : (same ? MUL_REPEAT : MUL_ISSUE);
      default: op_cycles = ONE_CYC;
    endcase
  endfunction

  assign go = wr_acc && (paddr == ADDR_CMD) && (state_r == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Operand and command registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_r <= 32'h00000000;
      opb_r <= 32'h00000000;
    end else if (clk_en && wr_acc) begin
      if (paddr == ADDR_OPA) begin
        opa_r <= pwdata;
      end
      if (paddr == ADDR_OPB) begin
        opb_r <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 32'h00000000;
    end else if (clk_en && go) begin
      cmd_r <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution timing: issue / repeat / latency

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      wait_r <= 6'h00;
      last_op_r <= 4'h0;
      timing_r <= 6'h00;
      busy <= 1'b0;
    end else if (clk_en) begin
      unique case (state_r)
        ST_IDLE: begin
          if (go) begin
            timing_r <= op_cycles(pwdata[3:0], pwdata[3:0] == last_op_r,
                                  pwdata[31]);
            wait_r <= op_cycles(pwdata[3:0], pwdata[3:0] == last_op_r, pwdata[31]);
            last_op_r <= pwdata[3:0];
            state_r <= ST_WAIT;
            busy <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (wait_r <= 6'h01) begin
            state_r <= ST_IDLE;
            busy <= 1'b0;
          end else begin
            wait_r <= wait_r - 6'h01;
          end
        end
      endcase
    end
  end

  wire logic done = (state_r == ST_WAIT) && (wait_r <= 6'h01);

  ////////////////////////////////////////////////////////////////////////////
  // Results and flags

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= 32'h00000000;
      third_r <= 32'h00000000;
      flags_r <= FLAGS_RST;
      cond_true <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        result_r <= res_nxt;
        third_r <= third_nxt;
        flags_r <= flags_nxt;
        cond_true <= eval_cond(cc, flags_r);
      end else if (wr_acc && paddr == ADDR_FLAGS) begin
        flags_r <= pwdata[FLAG_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_r <= FLAGS_RST;
    end else if (clk_en && wr_acc && paddr == ADDR_SAVED) begin
      saved_r <= pwdata[FLAG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_wp_r <= '0;
      hist_rp_r <= '0;
    end else if (clk_en) begin
      if (done) begin
        hist_wp_r <= hist_wp_r + HIST_AW'(1);
      end
      if (rd_acc && paddr == ADDR_HIST && pready) begin
        hist_rp_r <= hist_rp_r + HIST_AW'(1);
      end
    end
  end

  flag_hist_mem #(.DEPTH(HIST_DEPTH), .AW(HIST_AW), .DW(FLAG_W)) u_hist (
    .clk(pclk),
    .ce(clk_en),
    .we(done),
    .waddr(hist_wp_r),
    .wdata(flags_nxt),
    .raddr(hist_rp_r),
    .rdata(hist_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state per access

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= ADDR_HIST) && (a[1:0] == 2'b00);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      prdata <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          ADDR_OPA: prdata <= opa_r;
          ADDR_OPB: prdata <= opb_r;
          ADDR_CMD: prdata <= cmd_r;
          ADDR_FLAGS: prdata <= {27'h0000000, flags_r};
          ADDR_SAVED: prdata <= {27'h0000000, saved_r};
          ADDR_RESULT: prdata <= result_r;
          ADDR_THIRD: prdata <= third_r;
          ADDR_STATUS: prdata <= {30'h00000000, cond_true, busy};
          ADDR_TIMING: prdata <= {26'h0000000, timing_r};
          ADDR_HIST: prdata <= {27'h0000000, hist_rdata};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- flag_pkg.sv ----
// Package: constants, encodings and register map of the condition flag evaluator
package flag_pkg;
  localparam int WORD_W = 32;
  localparam int VEC_W = 5;
  localparam int BITNUM_W = 3;
  localparam int COND_W = 4;
  localparam int HIST_DEPTH = 8;
  localparam int HIST_AW = 3;

  // Condition codes
  localparam logic [3:0] CC_OVF = 4'h0;
  localparam logic [3:0] CC_CARRY = 4'h1;
  localparam logic [3:0] CC_ZERO = 4'h2;
  localparam logic [3:0] CC_NOT_HIGHER = 4'h3;
  localparam logic [3:0] CC_NEG = 4'h4;
  localparam logic [3:0] CC_ALWAYS = 4'h5;
  localparam logic [3:0] CC_LT = 4'h6;
  localparam logic [3:0] CC_LE = 4'h7;
  localparam logic [3:0] CC_NO_OVF = 4'h8;
  localparam logic [3:0] CC_NO_CARRY = 4'h9;
  localparam logic [3:0] CC_NOT_ZERO = 4'hA;
  localparam logic [3:0] CC_HIGHER = 4'hB;
  localparam logic [3:0] CC_POS = 4'hC;
  localparam logic [3:0] CC_SATURATED = 4'hD;
  localparam logic [3:0] CC_SIGNED_GREATER_EQUAL = 4'hE;
  localparam logic [3:0] CC_GT = 4'hF;

  // Flag field positions in the flag word
  localparam int FLAG_Z = 0;
  localparam int FLAG_S = 1;
  localparam int FLAG_OVERFLOW = 2;
  localparam int FLAG_CARRY = 3;
  localparam int FLAG_SATURATION = 4;
  localparam int FLAG_W = 5;

  // Per-flag update modes, two bits per flag
  localparam logic [1:0] UPD_KEEP = 2'h0;
  localparam logic [1:0] UPD_CLEAR = 2'h1;
  localparam logic [1:0] UPD_RESULT = 2'h2;
  localparam logic [1:0] UPD_RESTORE = 2'h3;

  // Operations
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_SATADD = 4'h2;
  localparam logic [3:0] OP_SATSUB = 4'h3;
  localparam logic [3:0] OP_SEXT = 4'h4;
  localparam logic [3:0] OP_ZEXT = 4'h5;
  localparam logic [3:0] OP_MUL = 4'h6;
  localparam logic [3:0] OP_MULU = 4'h7;
  localparam logic [3:0] OP_DIV = 4'h8;
  localparam logic [3:0] OP_DIVU = 4'h9;
  localparam logic [3:0] OP_SETBIT = 4'hA;
  localparam logic [3:0] OP_LOAD = 4'hB;
  localparam logic [3:0] OP_TRAP = 4'hC;

  // Access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Saturation bounds and trap base address
  localparam logic [31:0] CLAMP_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] CLAMP_MIN = 32'h80000000;
  localparam logic [31:0] TRAP_BASE = 32'h00000040;

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_OPA = 12'h000;
  localparam logic [11:0] ADDR_OPB = 12'h004;
  localparam logic [11:0] ADDR_CMD = 12'h008;
  localparam logic [11:0] ADDR_FLAGS = 12'h00C;
  localparam logic [11:0] ADDR_SAVED = 12'h010;
  localparam logic [11:0] ADDR_RESULT = 12'h014;
  localparam logic [11:0] ADDR_THIRD = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h01C;
  localparam logic [11:0] ADDR_TIMING = 12'h020;
  localparam logic [11:0] ADDR_HIST = 12'h024;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_CC_LSB = 4;
  localparam int CMD_SZ_LSB = 8;
  localparam int CMD_BIT_LSB = 10;
  localparam int CMD_UPD_LSB = 16;

  // Cycle figures: issue, repeat, latency for multiply; one total count for each divide
  localparam logic [5:0] DIV_CYC = 6'h23;
  localparam logic [5:0] DIVU_CYC = 6'h22;
  localparam logic [5:0] MUL_ISSUE = 6'h01;
  localparam logic [5:0] MUL_REPEAT = 6'h02;
  localparam logic [5:0] MUL_LATENCY = 6'h02;
  localparam logic [5:0] ONE_CYC = 6'h01;

  localparam logic [4:0] FLAGS_RST = 5'h00;
endpackage

// ---- flag_hist_mem.sv ----
// Small memory keeping a history of flag words, registered read
`timescale 1ns/100ps
module flag_hist_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 5
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ---- condition_flag_evaluator_monitor.sv ----
// Checker for the port behaviour of the condition flag evaluator
`timescale 1ns/100ps
module condition_flag_evaluator_monitor
  import flag_pkg::*;
#(
  parameter int DW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cond_true,
  input wire logic busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ready_wait;
    psel && penable && !$past(penable) && clk_en |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_in_access;
    pready |-> psel && penable && $past(penable);
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr alone");
  property p_unmapped_err;
    pready && (paddr > ADDR_HIST || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("no error on unmapped");
  property p_mapped_ok;
    pready && paddr <= ADDR_HIST && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("error on mapped");
  property p_err_read_zero;
    pready && pslverr && !pwrite |-> prdata == '0;
  endproperty
  a_err_read_zero: assert property (p_err_read_zero) else $error("unmapped data not zero");
  property p_div_busy;
    psel && penable && !pready && pwrite && clk_en && paddr == ADDR_CMD &&
      pwdata[3:0] == OP_DIV && !busy |=> busy [*8];
  endproperty
  a_div_busy: assert property (p_div_busy) else $error("divide not busy");
  property p_freeze;
    !clk_en |=> $stable(busy) && $stable(cond_true) && $stable(prdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_reset_quiet;
    $rose(presetn) |-> !busy && !cond_true && !pready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear after reset");
  c_div: cover property (pready && pwrite && paddr == ADDR_CMD && pwdata[3:0] == OP_DIV);
  c_err: cover property (pready && pslverr);
  c_cond: cover property ($rose(cond_true));
endmodule
bind condition_flag_evaluator condition_flag_evaluator_monitor #(.DW(DW)) u_mon (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cond_true(cond_true), .busy(busy)
);

// ---- condition_flag_evaluator_tb.sv ----
// Self-checking testbench for the condition flag evaluator
`timescale 1ns/100ps
module condition_flag_evaluator_tb;
  import flag_pkg::*;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] sz;
    logic chk3;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] res;
    logic [31:0] third;
  } row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cond_true;
  logic busy;
  logic [31:0] q;
  logic e;
  int n_errors = 0;
  int checks = 0;
  row_s rows [14] = '{
    '{OP_SATADD, SZ_WORD, 1'b0, 32'h7FFFFFF0, 32'h00000100, 32'h7FFFFFFF, 32'h0},
    '{OP_SATSUB, SZ_WORD, 1'b0, 32'h80000010, 32'h00000100, 32'h80000000, 32'h0},
    '{OP_SATADD, SZ_WORD, 1'b0, 32'h00000001, 32'h00000002, 32'h00000003, 32'h0},
    '{OP_SEXT, SZ_BYTE, 1'b0, 32'h00000080, 32'h0, 32'hFFFFFF80, 32'h0},
    '{OP_SEXT, SZ_HALF, 1'b0, 32'h12348001, 32'h0, 32'hFFFF8001, 32'h0},
    '{OP_ZEXT, SZ_BYTE, 1'b0, 32'hFFFFFF80, 32'h0, 32'h00000080, 32'h0},
    '{OP_ZEXT, SZ_HALF, 1'b0, 32'h12348001, 32'h0, 32'h00008001, 32'h0},
    '{OP_MULU, SZ_WORD, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000001, 32'hFFFFFFFE},
    '{OP_MUL, SZ_WORD, 1'b1, 32'hFFFFFFFE, 32'h00000003, 32'hFFFFFFFA, 32'hFFFFFFFF},
    '{OP_DIVU, SZ_WORD, 1'b1, 32'h00000064, 32'h00000007, 32'h0000000E, 32'h00000002},
    '{OP_DIV, SZ_WORD, 1'b1, 32'hFFFFFFF9, 32'h00000002, 32'hFFFFFFFD, 32'hFFFFFFFF},
    '{OP_TRAP, SZ_WORD, 1'b0, 32'h0000001F, 32'h0, 32'h0000005F, 32'h0},
    '{OP_SETBIT, SZ_WORD, 1'b0, 32'hFFFFFF10, 32'h0, 32'h00000011, 32'h0},
    '{OP_LOAD, SZ_HALF, 1'b0, 32'h5555A5A5, 32'h0, 32'hFFFFA5A5, 32'h0}
  };
  always #2 pclk = ~pclk;
  condition_flag_evaluator #(.DW(32)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cond_true(cond_true), .busy(busy)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    if (n == 20) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 60);
    if (q[0] !== 1'b0) chk("busy timeout", 32'h0, 32'h1);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] cc, input logic [1:0] sz,
                     input logic [9:0] upd, input logic [31:0] a, input logic [31:0] b);
    apb(1'b1, ADDR_OPA, a);
    apb(1'b1, ADDR_OPB, b);
    apb(1'b1, ADDR_CMD, {6'h00, upd, 6'h00, sz, cc, op});
    wait_idle();
  endtask
  function automatic logic cond_exp(input logic [3:0] cc, input logic [4:0] f);
    logic t;
    case (cc[2:0])
      3'h0: t = f[FLAG_OVERFLOW];
      3'h1: t = f[FLAG_CARRY];
      3'h2: t = f[FLAG_Z];
      3'h3: t = f[FLAG_CARRY] | f[FLAG_Z];
      3'h4: t = f[FLAG_S];
      3'h6: t = f[FLAG_S] ^ f[FLAG_OVERFLOW];
      default: t = (f[FLAG_S] ^ f[FLAG_OVERFLOW]) | f[FLAG_Z];
    endcase
    if (cc == CC_ALWAYS) return 1'b1;
    if (cc == CC_SATURATED) return f[FLAG_SATURATION];
    return t ^ cc[3];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #120000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, q);
    end
    foreach (rows[i]) begin
      cmd(rows[i].op, CC_ALWAYS, rows[i].sz, 10'h000, rows[i].a, rows[i].b);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk("result", rows[i].res, q);
      if (rows[i].chk3) begin
        apb(1'b0, ADDR_THIRD, 32'h0);
        chk("third register", rows[i].third, q);
      end
    end
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 32; f++) begin
        apb(1'b1, ADDR_FLAGS, 32'(f));
        cmd(OP_ADD, 4'(c), SZ_WORD, 10'h000, 32'h0, 32'h0);
        chk("cond_true", {31'h0, cond_exp(4'(c), 5'(f))}, {31'h0, cond_true});
        chk("status cond", {31'h0, cond_exp(4'(c), 5'(f))}, {31'h0, q[1]});
      end
    end
    // Zero from result, sign cleared, overflow kept, carry and saturation restored
    apb(1'b1, ADDR_FLAGS, 32'h0000000E);
    apb(1'b1, ADDR_SAVED, 32'h00000010);
    cmd(OP_ADD, CC_ALWAYS, SZ_WORD, 10'h3C6, 32'h0, 32'h0);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flag update", 32'h00000015, q);
    // Command while busy is ignored; freeze in mid-divide
    apb(1'b1, ADDR_OPA, 32'h00000064);
    apb(1'b1, ADDR_OPB, 32'h00000007);
    apb(1'b1, ADDR_CMD, {28'h0, OP_DIVU});
    apb(1'b1, ADDR_CMD, {28'h0, OP_ADD});
    chk("busy", 32'h1, {31'h0, busy});
    clk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    clk_en <= 1'b1;
    wait_idle();
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("result after refused command", 32'h0000000E, q);
    apb(1'b0, ADDR_TIMING, 32'h0);
    chk("divide cycles", {26'h0, DIVU_CYC}, q);
    apb(1'b0, 12'h028, 32'h0);
    chk("error beyond map", 32'h1, {31'h0, e});
    chk("error read data", 32'h0, q);
    apb(1'b0, 12'h002, 32'h0);
    chk("error misaligned", 32'h1, {31'h0, e});
    apb(1'b1, 12'hFFC, 32'hFFFFFFFF);
    chk("error write", 32'h1, {31'h0, e});
    // Reset in the middle of a divide
    apb(1'b1, ADDR_FLAGS, 32'h0000001F);
    apb(1'b1, ADDR_CMD, {28'h0, OP_DIV});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("busy after reset", 32'h0, {31'h0, busy});
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flags after reset", 32'h0, q);
    end_of_test();
  end
endmodule
